// [include/lsh_map.vh]
`ifndef LSH_MAP_VH
`define LSH_MAP_VH
// Register indices; byte address is four times the index
`define LSH_IDX_LOOP_CUR 8'h1C
`define LSH_IDX_LINE_VOLT 8'h1D
`define LSH_IDX_RSVD_A 8'h1E
`define LSH_IDX_CTRL4 8'h1F
`define LSH_IDX_THR_LEVEL 8'h2B
`define LSH_IDX_THR_CTRL 8'h2C
`define LSH_IDX_HOOK_AUX 8'h40
`define LSH_IDX_IRQ_STAT 8'h41
`define LSH_IDX_IRQ_MASK 8'h42
// Reset values
`define LSH_RST_CTRL4 8'h20
`define LSH_RST_THR_LEVEL 8'h00
`define LSH_RST_THR_CTRL 3'h0
`define LSH_RST_HOOK_AUX 5'h00
`define LSH_RST_IRQ_MASK 3'h0
// Control 4 fields
`define LSH_C4_FOH_HI 6
`define LSH_C4_FOH_LO 5
`define LSH_C4_OHS_EXT 3
`define LSH_C4_RXHP 1
`define LSH_C4_VFD 0
`define LSH_C4_WMASK 8'h6B
// Threshold control fields
`define LSH_TC_FLAG 3
`define LSH_TC_SRC 2
`define LSH_TC_MASK 1
`define LSH_TC_DIR 0
// Hook auxiliary fields
`define LSH_HA_OFFHOOK 0
`define LSH_HA_OHS_BASE 1
`define LSH_HA_SQ_LO 2
`define LSH_HA_SQ_HI 3
`define LSH_HA_GIE 4
`define LSH_HA_CLOSED 5
`define LSH_HA_SETTLED 6
// Interrupt status bits
`define LSH_EV_THR 0
`define LSH_EV_SETTLED 1
`define LSH_EV_RELEASED 2
`define LSH_EV_NUM 3
// Off-hook counter codes and the spark quench select code
`define LSH_FOH_512 2'b00
`define LSH_FOH_128 2'b01
`define LSH_FOH_64 2'b10
`define LSH_FOH_8 2'b11
`define LSH_SQ_QUENCH 2'b11
// Timing at 200 MHz
`define LSH_CYC_PER_MS 200000
`define LSH_CYC_PER_US 200
`define LSH_FOH_512_MS 512
`define LSH_FOH_128_MS 128
`define LSH_FOH_64_MS 64
`define LSH_FOH_8_MS 8
`define LSH_REL_FAST_US 500
`define LSH_REL_EXT_MS 3
`define LSH_REL_QUENCH_MS 26
// Line voltage floor, volts
`define LSH_VFLOOR_V 8'h03
`endif

// [core/lsh_ctrl.v]
`timescale 1ns/1ps
`include "lsh_map.vh"

module lsh_ctrl #(
  parameter ADDR_W = 10,
  parameter FOH_512_CYC = `LSH_FOH_512_MS * `LSH_CYC_PER_MS,
  parameter FOH_128_CYC = `LSH_FOH_128_MS * `LSH_CYC_PER_MS,
  parameter FOH_64_CYC = `LSH_FOH_64_MS * `LSH_CYC_PER_MS,
  parameter FOH_8_CYC = `LSH_FOH_8_MS * `LSH_CYC_PER_MS,
  parameter REL_FAST_CYC = `LSH_REL_FAST_US * `LSH_CYC_PER_US - 1,
  parameter REL_EXT_CYC = `LSH_REL_EXT_MS * `LSH_CYC_PER_MS,
  parameter REL_QUENCH_CYC = `LSH_REL_QUENCH_MS * `LSH_CYC_PER_MS
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Measurement samples from the line-side converter
  input wire [7:0] loop_current_sample,
  input wire loop_current_update,
  input wire [7:0] line_voltage_sample,
  input wire line_voltage_update,
  // Line controls
  output reg hook_closed,
  output reg offhook_settled,
  output reg rx_highpass_select,
  // Interrupt
  output reg irq
);

  localparam ST_IDLE = 2'b00;
  localparam ST_COUNT = 2'b01;
  localparam ST_SETTLED = 2'b10;
  localparam ST_RELEASE = 2'b11;

  function sel_hit;
    input [7:0] idx;
    input [7:0] target;
    begin
      sel_hit = (idx == target);
    end
  endfunction

  function [7:0] abs8;
    input [7:0] v;
    begin
      abs8 = v[7] ? (~v + 8'h01) : v;
    end
  endfunction

  // Bus phase tracking
  reg wr_pend;
  reg [7:0] wr_idx;
  wire take = hsel & htrans[1] & hready;
  wire rd_take = take & ~hwrite;
  wire wr_now = wr_pend;
  wire [7:0] rd_idx = haddr[9:2];

  // Register state
  reg [7:0] line_control_four;
  reg [7:0] threshold_level_reg;
  reg [2:0] thr_ctrl;
  reg threshold_flag;
  reg [4:0] hook_aux;
  reg [`LSH_EV_NUM-1:0] irq_status;
  reg [`LSH_EV_NUM-1:0] irq_mask;
  reg [7:0] loop_current_value;
  reg [7:0] line_voltage_value;

  // Hook sequencer
  reg [1:0] state;
  reg [31:0] cnt;
  reg [1:0] next_state;
  reg [31:0] next_cnt;
  reg ev_settled;
  reg ev_released;
  reg [31:0] foh_cycles;
  reg [31:0] rel_cycles;

  // Threshold path
  wire [`LSH_EV_NUM-1:0] events;
  reg [7:0] rd_val;

  wire offhook_request = hook_aux[`LSH_HA_OFFHOOK];
  wire onhook_speed_base = hook_aux[`LSH_HA_OHS_BASE];
  wire [1:0] spark_quench_sel = hook_aux[`LSH_HA_SQ_HI:`LSH_HA_SQ_LO];
  wire global_irq_enable = hook_aux[`LSH_HA_GIE];
  wire [1:0] fast_offhook_select = line_control_four[`LSH_C4_FOH_HI:`LSH_C4_FOH_LO];
  wire onhook_speed_ext = line_control_four[`LSH_C4_OHS_EXT];
  wire volt_floor_disable = line_control_four[`LSH_C4_VFD];
  wire threshold_source = thr_ctrl[`LSH_TC_SRC];
  wire threshold_irq_mask = thr_ctrl[`LSH_TC_MASK];
  wire threshold_direction = thr_ctrl[`LSH_TC_DIR];
  wire thr_en = threshold_irq_mask & global_irq_enable;

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else begin
      wr_pend <= take & hwrite;
      wr_idx <= haddr[9:2];
    end
  end

  // Software-owned control registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_control_four <= `LSH_RST_CTRL4;
      threshold_level_reg <= `LSH_RST_THR_LEVEL;
      thr_ctrl <= `LSH_RST_THR_CTRL;
      hook_aux <= `LSH_RST_HOOK_AUX;
      irq_mask <= `LSH_RST_IRQ_MASK;
    end else if (wr_now) begin
      if (sel_hit(wr_idx, `LSH_IDX_CTRL4))
        line_control_four <= hwdata[7:0] & `LSH_C4_WMASK;
      if (sel_hit(wr_idx, `LSH_IDX_THR_LEVEL))
        threshold_level_reg <= hwdata[7:0];
      if (sel_hit(wr_idx, `LSH_IDX_THR_CTRL))
        thr_ctrl <= hwdata[2:0];
      if (sel_hit(wr_idx, `LSH_IDX_HOOK_AUX))
        hook_aux <= hwdata[4:0];
      if (sel_hit(wr_idx, `LSH_IDX_IRQ_MASK))
        irq_mask <= hwdata[`LSH_EV_NUM-1:0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rx_highpass_select <= 1'b0;
    else
      rx_highpass_select <= line_control_four[`LSH_C4_RXHP];
  end

  // Off-hook counter length
  always @* begin
    case (fast_offhook_select)
      `LSH_FOH_512: foh_cycles = FOH_512_CYC;
      `LSH_FOH_128: foh_cycles = FOH_128_CYC;
      `LSH_FOH_64: foh_cycles = FOH_64_CYC;
      default: foh_cycles = FOH_8_CYC;
    endcase
  end

  // Release time; undefined speed mixes fall back to the fast release
  always @* begin
    if (onhook_speed_base && spark_quench_sel == `LSH_SQ_QUENCH)
      rel_cycles = REL_QUENCH_CYC;
    else if (!onhook_speed_base && onhook_speed_ext)
      rel_cycles = REL_EXT_CYC;
    else
      rel_cycles = REL_FAST_CYC;
  end

  always @* begin
    next_state = state;
    next_cnt = cnt;
    ev_settled = 1'b0;
    ev_released = 1'b0;
    case (state)
      ST_IDLE: begin
        if (offhook_request) begin
          next_state = ST_COUNT;
          next_cnt = foh_cycles;
        end
      end
      ST_COUNT: begin
        if (!offhook_request) begin
          next_state = ST_RELEASE;
          next_cnt = rel_cycles;
        end else if (cnt <= 32'h0000_0001) begin
          next_state = ST_SETTLED;
          ev_settled = 1'b1;
        end else begin
          next_cnt = cnt - 32'h0000_0001;
        end
      end
      ST_SETTLED: begin
        if (!offhook_request) begin
          next_state = ST_RELEASE;
          next_cnt = rel_cycles;
        end
      end
      ST_RELEASE: begin
        // Loop held closed until the release time runs out
        if (cnt <= 32'h0000_0001) begin
          next_state = ST_IDLE;
          ev_released = 1'b1;
        end else begin
          next_cnt = cnt - 32'h0000_0001;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      cnt <= 32'h0000_0000;
      hook_closed <= 1'b0;
      offhook_settled <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      hook_closed <= (next_state != ST_IDLE);
      offhook_settled <= (next_state == ST_SETTLED);
    end
  end

  // Line voltage floor; a 0 V sample passes as zero either way
  wire [7:0] volt_abs = abs8(line_voltage_sample);
  wire [7:0] next_volt = (!volt_floor_disable && volt_abs <= `LSH_VFLOOR_V) ?
    8'h00 : line_voltage_sample;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loop_current_value <= 8'h00;
      line_voltage_value <= 8'h00;
    end else begin
      if (loop_current_update)
        loop_current_value <= loop_current_sample;
      if (line_voltage_update)
        line_voltage_value <= next_volt;
    end
  end

  // Compare the fresh value, not the stored one, so no update is missed
  wire sel_update = threshold_source ? line_voltage_update :
    loop_current_update;
  wire [7:0] sel_abs = threshold_source ? abs8(next_volt) :
    loop_current_sample;
  wire crossing = sel_update & (threshold_direction ?
    (sel_abs > threshold_level_reg) : (sel_abs < threshold_level_reg));

  // Write of zero clears; a crossing in the same cycle wins
  wire thr_clear = wr_now & sel_hit(wr_idx, `LSH_IDX_THR_CTRL) &
    ~hwdata[`LSH_TC_FLAG];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      threshold_flag <= 1'b0;
    else if (crossing)
      threshold_flag <= 1'b1;
    else if (thr_clear)
      threshold_flag <= 1'b0;
  end

  // Read-clear event status, set wins over the clear
  assign events[`LSH_EV_THR] = crossing;
  assign events[`LSH_EV_SETTLED] = ev_settled;
  assign events[`LSH_EV_RELEASED] = ev_released;

  genvar gi;
  generate
    for (gi = 0; gi < `LSH_EV_NUM; gi = gi + 1) begin : g_evt
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          irq_status[gi] <= 1'b0;
        else if (events[gi])
          irq_status[gi] <= 1'b1;
        else if (rd_take && sel_hit(rd_idx, `LSH_IDX_IRQ_STAT))
          irq_status[gi] <= 1'b0;
      end
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= (|(irq_status & irq_mask & {{(`LSH_EV_NUM-1){1'b1}}, thr_en})) |
        (threshold_flag & thr_en);
  end

  // Read mux; unmapped and reserved words read as zero
  always @* begin
    rd_val = 8'h00;
    if (sel_hit(rd_idx, `LSH_IDX_LOOP_CUR))
      rd_val = loop_current_value;
    if (sel_hit(rd_idx, `LSH_IDX_LINE_VOLT))
      rd_val = line_voltage_value;
    if (sel_hit(rd_idx, `LSH_IDX_CTRL4))
      rd_val = line_control_four;
    if (sel_hit(rd_idx, `LSH_IDX_THR_LEVEL))
      rd_val = threshold_level_reg;
    if (sel_hit(rd_idx, `LSH_IDX_THR_CTRL))
      rd_val = {4'h0, threshold_flag, thr_ctrl};
    if (sel_hit(rd_idx, `LSH_IDX_HOOK_AUX))
      rd_val = {1'b0, offhook_settled, hook_closed, hook_aux};
    if (sel_hit(rd_idx, `LSH_IDX_IRQ_STAT))
      rd_val = {5'h00, irq_status};
    if (sel_hit(rd_idx, `LSH_IDX_IRQ_MASK))
      rd_val = {5'h00, irq_mask};
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_take)
      hrdata <= {24'h00_0000, rd_val};
    else
      hrdata <= 32'h0000_0000;
  end

endmodule // lsh_ctrl

// [verif/lsh_ctrl_asserts.sv]
`timescale 1ns/1ps
`include "lsh_map.vh"
module lsh_ctrl_chk (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus
  input wire hsel,
  input wire [9:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  // Line and interrupt
  input wire hook_closed,
  input wire offhook_settled,
  input wire rx_highpass_select,
  input wire irq
);
  reg dv;
  reg dw;
  reg [7:0] da;
  reg [7:0] thr;
  reg [7:0] c4;
  reg [3:0] act;
  wire tk = hsel & htrans[1] & hready;
  wire rd = dv & ~dw;
  wire wr = dv & dw;
  wire hp_w = hwdata[`LSH_C4_RXHP];
  // Shadows follow bus writes; only valid while the bench never pipelines a read behind a write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dv <= 1'h0;
      dw <= 1'h0;
      da <= 8'h00;
      act <= 4'h0;
      thr <= `LSH_RST_THR_LEVEL;
      c4 <= `LSH_RST_CTRL4;
    end else begin
      dv <= tk;
      dw <= hwrite;
      da <= haddr[9:2];
      act <= {act[2:0], tk};
      if (wr && da == `LSH_IDX_THR_LEVEL)
        thr <= hwdata[7:0];
      if (wr && da == `LSH_IDX_CTRL4)
        c4 <= hwdata[7:0] & `LSH_C4_WMASK;
    end
  end
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_rd_idle;
    !rd |-> hrdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  property p_thr;
    rd && da == `LSH_IDX_THR_LEVEL |-> hrdata == {24'h0, thr};
  endproperty
  a_thr: assert property (p_thr) else $error("threshold readback wrong");
  property p_c4;
    rd && da == `LSH_IDX_CTRL4 |-> hrdata == {24'h0, c4};
  endproperty
  a_c4: assert property (p_c4) else $error("control readback wrong");
  property p_hp;
    wr && da == `LSH_IDX_CTRL4 |-> ##2 rx_highpass_select == $past(hp_w, 2);
  endproperty
  a_hp: assert property (p_hp) else $error("highpass select not applied");
  property p_set;
    $rose(offhook_settled) |-> $past(hook_closed, 8);
  endproperty
  a_set: assert property (p_set) else $error("settled too early");
  property p_set_hook;
    offhook_settled |-> hook_closed;
  endproperty
  a_set_hook: assert property (p_set_hook) else $error("settled without hook");
  property p_rel;
    $fell(hook_closed) |-> $past(offhook_settled, 8) == 1'h0;
  endproperty
  a_rel: assert property (p_rel) else $error("release too fast");
  property p_irq_fall;
    $fell(irq) |-> act != 4'h0;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule // lsh_ctrl_chk

bind lsh_ctrl lsh_ctrl_chk lsh_ctrl_chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hook_closed, .offhook_settled, .rx_highpass_select, .irq);

// [verif/lsh_conv_model.sv]
`timescale 1ns/1ps
module lsh_conv_model (
  // Clock
  input wire hclk,
  // Samples
  output reg [7:0] loop_current_sample = 8'h5A,
  output reg loop_current_update = 1'h0,
  output reg [7:0] line_voltage_sample = 8'hA5,
  output reg line_voltage_update = 1'h0
);
  // Between updates the value is inverted so stale data never looks valid
  task send(input logic src, input logic [7:0] v, input int gap);
    repeat (gap) @(posedge hclk);
    if (src) begin
      line_voltage_sample <= v;
      line_voltage_update <= 1'h1;
    end else begin
      loop_current_sample <= v;
      loop_current_update <= 1'h1;
    end
    @(posedge hclk);
    if (src) begin
      line_voltage_sample <= ~v;
      line_voltage_update <= 1'h0;
    end else begin
      loop_current_sample <= ~v;
      loop_current_update <= 1'h0;
    end
  endtask
endmodule // lsh_conv_model

// [verif/lsh_ctrl_tb_top.sv]
`timescale 1ns/1ps
`include "lsh_map.vh"
module lsh_ctrl_tb_top;
  localparam int FAST_OFFHOOK_SELECT [4] = '{40, 30, 20, 12};
  localparam int REL [3] = '{14, 24, 34};
  localparam logic [16:0] FLR [5] = '{{1'h0, 8'h03, 8'h00}, {1'h0, 8'hFD, 8'h00},
    {1'h0, 8'h04, 8'h04}, {1'h1, 8'h03, 8'h03}, {1'h1, 8'h00, 8'h00}};
  reg hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, rdph = 1'h0;
  reg [1:0] htrans = 2'h0;
  reg [2:0] hsize = 3'h2;
  reg [9:0] haddr = 10'h000;
  reg [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, hook_closed, offhook_settled, rx_highpass_select, irq;
  wire loop_current_update, line_voltage_update;
  wire [7:0] loop_current_sample, line_voltage_sample;
  int n_fail = 0;
  int num_checks = 0;
  logic [31:0] q [$];

  initial forever #2.5 hclk = ~hclk;

  // Short counts keep the run small; expectations use the same table
  lsh_ctrl #(.FOH_512_CYC(FAST_OFFHOOK_SELECT[0]), .FOH_128_CYC(FAST_OFFHOOK_SELECT[1]), .FOH_64_CYC(FAST_OFFHOOK_SELECT[2]),
    .FOH_8_CYC(FAST_OFFHOOK_SELECT[3]), .REL_FAST_CYC(REL[0]), .REL_EXT_CYC(REL[1]),
    .REL_QUENCH_CYC(REL[2])) lsh_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .loop_current_sample, .loop_current_update, .line_voltage_sample,
    .line_voltage_update, .hook_closed, .offhook_settled, .rx_highpass_select, .irq);
  lsh_conv_model lsh_conv_model_i (.hclk, .loop_current_sample, .loop_current_update,
    .line_voltage_sample, .line_voltage_update);

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Mode 0 waits for settled, 1 for hook release, 2 for bus ready
  task cnt(input int m, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((m == 2 ? hreadyout !== 1'h1 : m ? hook_closed : !offhook_settled) && n < 300);
    if (n >= 300) begin
      n_fail++;
      give_verdict;
    end
  endtask

  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {idx, 2'h0};
    cnt(2, n);
    hsel <= 1'h0;
    htrans <= 2'h0;
    if (w)
      hwdata <= {24'h0, d};
    else
      q.push_back({24'h0, d});
    cnt(2, n);
  endtask

  always @(posedge hclk) begin
    if (rdph)
      chk(hrdata, q.pop_front());
    rdph <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  initial begin
    logic [7:0] v;
    logic [7:0] tv;
    logic [7:0] nt;
    int n;
    int e;
    void'($urandom(295));
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(0, `LSH_IDX_CTRL4, `LSH_RST_CTRL4);
    bus(0, `LSH_IDX_THR_LEVEL, `LSH_RST_THR_LEVEL);
    bus(0, `LSH_IDX_RSVD_A, 8'h00);
    bus(0, 8'hFF, 8'h00);
    for (int c = 0; c < 4; c++) begin
      v = $urandom;
      bus(1, `LSH_IDX_CTRL4, v);
      bus(0, `LSH_IDX_CTRL4, v & `LSH_C4_WMASK);
      chk({31'h0, rx_highpass_select}, {31'h0, v[1]});
      v = $urandom;
      bus(1, `LSH_IDX_THR_LEVEL, v);
      bus(0, `LSH_IDX_THR_LEVEL, v);
    end
    foreach (FLR[i]) begin
      bus(1, `LSH_IDX_CTRL4, {7'h0, FLR[i][16]});
      lsh_conv_model_i.send(1, FLR[i][15:8], $urandom_range(3));
      bus(0, `LSH_IDX_LINE_VOLT, FLR[i][7:0]);
    end
    bus(1, `LSH_IDX_THR_LEVEL, 8'h40);
    bus(1, `LSH_IDX_HOOK_AUX, 8'h10);
    for (int c = 0; c < 4; c++) begin
      tv = c[0] ? (c[1] ? 8'hB0 : 8'h80) : 8'h10;
      nt = c[0] ? 8'h10 : (c[1] ? 8'hB0 : 8'h80);
      bus(1, `LSH_IDX_THR_CTRL, {5'h0, c[1], 1'h1, c[0]});
      lsh_conv_model_i.send(!c[1], tv, $urandom_range(3));
      lsh_conv_model_i.send(c[1], nt, 0);
      repeat (3) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      lsh_conv_model_i.send(c[1], tv, 0);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h1);
      bus(0, `LSH_IDX_IRQ_STAT, 8'h01);
      bus(0, `LSH_IDX_THR_CTRL, {4'h0, 1'h1, c[1], 1'h1, c[0]});
      chk({31'h0, irq}, 32'h1);
      bus(1, `LSH_IDX_HOOK_AUX, 8'h00);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      bus(1, `LSH_IDX_HOOK_AUX, 8'h10);
      bus(1, `LSH_IDX_THR_CTRL, 8'h00);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
    end
    for (int c = 0; c < 4; c++) begin
      e = c % 3;
      bus(1, `LSH_IDX_CTRL4, {1'h0, c[1:0], 1'h0, e == 1, 3'h0});
      bus(1, `LSH_IDX_HOOK_AUX, {4'h0, e == 2 ? 2'h3 : 2'h0, e == 2, 1'h1});
      cnt(0, n);
      chk({31'h0, n >= FAST_OFFHOOK_SELECT[c] && n <= FAST_OFFHOOK_SELECT[c] + 3}, 32'h1);
      bus(1, `LSH_IDX_HOOK_AUX, {4'h0, e == 2 ? 2'h3 : 2'h0, e == 2, 1'h0});
      cnt(1, n);
      chk({31'h0, n >= REL[e] && n <= REL[e] + 3}, 32'h1);
    end
    bus(0, `LSH_IDX_IRQ_STAT, 8'h06);
    bus(0, `LSH_IDX_IRQ_STAT, 8'h00);
    give_verdict;
  end
endmodule // lsh_ctrl_tb_top
